/* File: cal_pkg.sv */
// Purpose: constants shared by the calendar window, trim and alarm block
// Assumes: 125 MHz system clock, 32.768 kHz calendar clock arriving on a pin
// Notes:   times are BCD bytes; pointers are two bits
//
// Overview of operation
// - time window pointer picks min/sec, weekday/hours, month/day or year-only pair
// - time window high byte access decrements its pointer, holding at 00
// - alarm pointer picks min/sec, weekday/hours, month/day; code 11 maps nothing
// - alarm window high byte access decrements alarm pointer, holding at 00
// - once a minute the timer shifts by signed trim times four pulses
// - negative trim adds pulses per minute, positive trim removes them
// - an issued alarm clears enable unless endless repeat or count nonzero
// - four-bit interval select picks half second up to yearly period
// - yearly alarm fires each year, except a February 29 date
// - zero count without endless gives one alarm; FFh gives 255 repeats
// - each alarm decrements count; at 00 one last alarm then disable
// - endless repeat keeps alarm on; count wraps to FF
// - every alarm event raises an interrupt request
// - alarm pulse toggles per event, half alarm rate, even duty for half-second and one-second intervals
// - pin select 00 drives alarm pulse, else the one-second clock
// - alarm works in low-power modes and raises a wake request
// - unlock bit set accepted only within one instruction cycle of key
// - time window writes ignored while unlock bit clear

package cal_pkg;
    // ==========================================
    // timing
    localparam int CLK_PERIOD_NS     = 8;
    localparam int UNLOCK_WINDOW_NS  = 32;
    localparam int UNLOCK_WINDOW_CYC = (UNLOCK_WINDOW_NS / CLK_PERIOD_NS < 1) ? 1
                                       : UNLOCK_WINDOW_NS / CLK_PERIOD_NS;
    localparam int HALF_SEC_PULSES   = 16384;
    localparam int ROLL_WIN_PULSES   = 32;
    localparam int TRIM_SHIFT        = 2;
    // ==========================================
    // codes
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [1:0] PTR_MINSEC = 2'h0;
    localparam logic [1:0] PTR_WDHR   = 2'h1;
    localparam logic [1:0] PTR_MONDAY = 2'h2;
    localparam logic [1:0] PTR_YEAR   = 2'h3;
    localparam logic [1:0] PIN_ALARM  = 2'h0;
    localparam logic [3:0] IV_HALF    = 4'h0;
    localparam logic [3:0] IV_SEC     = 4'h1;
    localparam logic [3:0] IV_10SEC   = 4'h2;
    localparam logic [3:0] IV_MIN     = 4'h3;
    localparam logic [3:0] IV_10MIN   = 4'h4;
    localparam logic [3:0] IV_HOUR    = 4'h5;
    localparam logic [3:0] IV_DAY     = 4'h6;
    localparam logic [3:0] IV_WEEK    = 4'h7;
    localparam logic [3:0] IV_MONTH   = 4'h8;
    localparam logic [3:0] IV_YEAR    = 4'h9;
    localparam logic [7:0] RPT_WRAP   = 8'hff;
    // ==========================================
    // reset values and bcd limits
    localparam logic [7:0] RST_DAY    = 8'h01;
    localparam logic [7:0] RST_MONTH  = 8'h01;
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [7:0] BCD_59     = 8'h59;
    localparam logic [7:0] BCD_23     = 8'h23;
    localparam logic [7:0] BCD_WD_MAX = 8'h06;
    localparam logic [7:0] BCD_12     = 8'h12;
    localparam logic [7:0] BCD_99     = 8'h99;

    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_OPEN} key_state_t;
endpackage : cal_pkg

/* File: trim_prescaler.sv */
// Purpose: half-second prescaler on the calendar clock with per-minute trim
// Assumes: cal_clk_pin is asynchronous to clock
// Notes:   trim loads a signed start value at the end of each minute
`timescale 1ns/10ps
module trim_prescaler
    import cal_pkg::*;
#(
    parameter int HALF_PULSES = HALF_SEC_PULSES
) (
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       cal_clk_pin,
    input  wire logic       run,
    input  wire logic       clear,
    input  wire logic       minute_last,
    input  wire logic [7:0] trim,
    output logic            half_tick_q,
    output logic            sec_tick_q,
    output logic            half_phase_q,
    output logic            rollover_q
);
    // ==========================================
    // pin synchroniser and edge
    logic               s1_q;
    logic               s2_q;
    logic               s3_q;
    logic signed [16:0] cnt_q;
    wire                pulse    = s2_q & ~s3_q;
    wire                at_end   = (cnt_q == 17'(HALF_PULSES - 1));
    wire                advance  = run & pulse;
    wire signed [16:0]  trim_ext = {{7{trim[7]}}, trim, 2'b00};
    wire signed [16:0]  restart  = (half_phase_q & minute_last) ? trim_ext : '0;
    wire                near_end = cnt_q >= 17'(HALF_PULSES - ROLL_WIN_PULSES);

    always_ff @(posedge clock) begin
        if (srst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= cal_clk_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ==========================================
    // counter: start above zero removes pulses, below zero adds them
    always_ff @(posedge clock) begin
        if (srst || clear) begin
            cnt_q        <= '0;
            half_phase_q <= 1'b0;
        end else if (advance && at_end) begin
            cnt_q        <= restart;
            half_phase_q <= ~half_phase_q;
        end else if (advance) begin
            cnt_q <= cnt_q + 17'sd1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            half_tick_q <= 1'b0;
            sec_tick_q  <= 1'b0;
            rollover_q  <= 1'b0;
        end else begin
            half_tick_q <= advance & at_end & ~clear;
            sec_tick_q  <= advance & at_end & half_phase_q & ~clear;
            rollover_q  <= run & half_phase_q & near_end;
        end
    end
endmodule : trim_prescaler

/* File: calendar_window_alarm_trim.sv */
// Purpose: pointer windows, write lock, drift trim and alarm of the calendar clock
// Assumes: cpu strobes are one-cycle pulses on clock; calendar clock on a pin
// Notes:   read data are captured on the read strobe's edge
`timescale 1ns/10ps
module calendar_window_alarm_trim
    import cal_pkg::*;
#(
    parameter int HALF_PULSES = HALF_SEC_PULSES
) (
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       cal_clk_pin,
    input  wire logic       timer_enable,
    input  wire logic       key_wr,
    input  wire logic [7:0] key_wdata,
    input  wire logic       unlock_wr,
    input  wire logic       unlock_wdata,
    input  wire logic       time_ptr_wr,
    input  wire logic [1:0] time_ptr_wdata,
    input  wire logic       time_hi_wr,
    input  wire logic       time_lo_wr,
    input  wire logic       time_hi_rd,
    input  wire logic       time_lo_rd,
    input  wire logic [7:0] time_wdata,
    input  wire logic       alarm_ptr_wr,
    input  wire logic [1:0] alarm_ptr_wdata,
    input  wire logic       alarm_hi_wr,
    input  wire logic       alarm_lo_wr,
    input  wire logic       alarm_hi_rd,
    input  wire logic       alarm_lo_rd,
    input  wire logic [7:0] alarm_wdata,
    input  wire logic       alarm_cfg_wr,
    input  wire logic       cfg_enable,
    input  wire logic       cfg_endless,
    input  wire logic [3:0] cfg_interval,
    input  wire logic       repeat_wr,
    input  wire logic [7:0] repeat_wdata,
    input  wire logic       trim_wr,
    input  wire logic [7:0] trim_wdata,
    input  wire logic       pin_sel_wr,
    input  wire logic [1:0] pin_sel_wdata,
    output logic            timer_write_unlock_q,
    output logic [1:0]      time_window_pointer_q,
    output logic [1:0]      alarm_window_pointer_q,
    output logic [7:0]      time_window_high_q,
    output logic [7:0]      time_window_low_q,
    output logic [7:0]      alarm_window_high_q,
    output logic [7:0]      alarm_window_low_q,
    output logic            alarm_enable_bit_q,
    output logic            endless_repeat_q,
    output logic [3:0]      alarm_interval_select_q,
    output logic [7:0]      alarm_repeat_count_q,
    output logic [7:0]      drift_trim_value_q,
    output logic [1:0]      output_pin_select_q,
    output logic            rollover_pending_flag,
    output logic            half_sec_phase,
    output logic            alarm_irq_q,
    output logic            wake_req_q,
    output logic            alarm_pulse_q,
    output logic            cal_out_pin_q
);
    // ==========================================
    // bcd helpers
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        if (m == 8'h02)
            month_days = leap ? 8'h29 : 8'h28;
        else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
            month_days = 8'h30;
        else
            month_days = 8'h31;
    endfunction : month_days

    // ==========================================
    // state
    logic [7:0] sec_q, min_q, hr_q, wd_q, day_q, mon_q, yr_q;
    logic [7:0] asec_q, amin_q, ahr_q, awd_q, aday_q, amon_q;
    key_state_t key_q;
    logic [7:0] win_cnt_q;
    logic       chk_q;
    logic       half_tick;
    logic       sec_tick;

    // ==========================================
    // prescaler with trim
    trim_prescaler #(.HALF_PULSES(HALF_PULSES)) u_presc (
        .clock       (clock),
        .srst        (srst),
        .cal_clk_pin (cal_clk_pin),
        .run         (timer_enable),
        .clear       (time_lo_wr && timer_write_unlock_q && time_window_pointer_q == PTR_MINSEC),
        .minute_last (sec_q == BCD_59),
        .trim        (drift_trim_value_q),
        .half_tick_q (half_tick),
        .sec_tick_q  (sec_tick),
        .half_phase_q(half_sec_phase),
        .rollover_q  (rollover_pending_flag)
    );

    // ==========================================
    // unlock key sequence
    wire key_ok     = key_q == KEY_OPEN;
    wire unlock_set = unlock_wr & unlock_wdata & key_ok;

    always_ff @(posedge clock) begin
        if (srst) begin
            key_q     <= KEY_IDLE;
            win_cnt_q <= '0;
        end else begin
            case (key_q)
                KEY_IDLE: begin
                    if (key_wr && key_wdata == KEY_FIRST)
                        key_q <= KEY_GOT_FIRST;
                end
                KEY_GOT_FIRST: begin
                    if (key_wr && key_wdata == KEY_SECOND) begin
                        key_q     <= KEY_OPEN;
                        win_cnt_q <= 8'(UNLOCK_WINDOW_CYC - 1);
                    end else if (key_wr) begin
                        key_q <= KEY_IDLE;
                    end
                end
                default: begin
                    if (win_cnt_q == 8'h00 || unlock_wr || key_wr)
                        key_q <= KEY_IDLE;
                    else
                        win_cnt_q <= win_cnt_q - 8'h01;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst)
            timer_write_unlock_q <= 1'b0;
        else if (unlock_wr)
            timer_write_unlock_q <= unlock_set;
    end

    // ==========================================
    // window pointers
    wire tp_dec = (time_hi_wr | time_hi_rd) && time_window_pointer_q != PTR_MINSEC;
    wire ap_dec = (alarm_hi_wr | alarm_hi_rd) && alarm_window_pointer_q != PTR_MINSEC;

    always_ff @(posedge clock) begin
        if (srst) begin
            time_window_pointer_q  <= PTR_MINSEC;
            alarm_window_pointer_q <= PTR_MINSEC;
        end else begin
            if (time_ptr_wr)
                time_window_pointer_q <= time_ptr_wdata;
            else if (tp_dec)
                time_window_pointer_q <= time_window_pointer_q - 2'h1;
            if (alarm_ptr_wr)
                alarm_window_pointer_q <= alarm_ptr_wdata;
            else if (ap_dec)
                alarm_window_pointer_q <= alarm_window_pointer_q - 2'h1;
        end
    end

    // ==========================================
    // window read muxes
    wire [1:0] tp = time_window_pointer_q;
    wire [1:0] ap = alarm_window_pointer_q;
    wire [7:0] t_hi = (tp == PTR_MINSEC) ? min_q : (tp == PTR_WDHR) ? wd_q
                    : (tp == PTR_MONDAY) ? mon_q : 8'h00;
    wire [7:0] t_lo = (tp == PTR_MINSEC) ? sec_q : (tp == PTR_WDHR) ? hr_q
                    : (tp == PTR_MONDAY) ? day_q : yr_q;
    wire [7:0] a_hi = (ap == PTR_MINSEC) ? amin_q : (ap == PTR_WDHR) ? awd_q
                    : (ap == PTR_MONDAY) ? amon_q : 8'h00;
    wire [7:0] a_lo = (ap == PTR_MINSEC) ? asec_q : (ap == PTR_WDHR) ? ahr_q
                    : (ap == PTR_MONDAY) ? aday_q : 8'h00;

    always_ff @(posedge clock) begin
        if (srst) begin
            time_window_high_q  <= '0;
            time_window_low_q   <= '0;
            alarm_window_high_q <= '0;
            alarm_window_low_q  <= '0;
        end else begin
            if (time_hi_rd)  time_window_high_q  <= t_hi;
            if (time_lo_rd)  time_window_low_q   <= t_lo;
            if (alarm_hi_rd) alarm_window_high_q <= a_hi;
            if (alarm_lo_rd) alarm_window_low_q  <= a_lo;
        end
    end

    // ==========================================
    // time registers: window write wins over counting
    wire tw_hi = time_hi_wr & timer_write_unlock_q;
    wire tw_lo = time_lo_wr & timer_write_unlock_q;
    wire c_min = sec_tick & (sec_q == BCD_59);
    wire c_hr  = c_min & (min_q == BCD_59);
    wire c_day = c_hr & (hr_q == BCD_23);
    wire c_mon = c_day & (day_q == month_days(mon_q, yr_q));
    wire c_yr  = c_mon & (mon_q == BCD_12);

    always_ff @(posedge clock) begin
        if (srst) begin
            {sec_q, min_q, hr_q, wd_q, yr_q} <= {5{RST_ZERO}};
            day_q <= RST_DAY;
            mon_q <= RST_MONTH;
        end else begin
            if (tw_lo && tp == PTR_MINSEC) sec_q <= time_wdata;
            else if (sec_tick) sec_q <= c_min ? RST_ZERO : bcd_inc(sec_q);
            if (tw_hi && tp == PTR_MINSEC) min_q <= time_wdata;
            else if (c_min) min_q <= c_hr ? RST_ZERO : bcd_inc(min_q);
            if (tw_lo && tp == PTR_WDHR) hr_q <= time_wdata;
            else if (c_hr) hr_q <= c_day ? RST_ZERO : bcd_inc(hr_q);
            if (tw_hi && tp == PTR_WDHR) wd_q <= time_wdata;
            else if (c_day) wd_q <= (wd_q == BCD_WD_MAX) ? RST_ZERO : bcd_inc(wd_q);
            if (tw_lo && tp == PTR_MONDAY) day_q <= time_wdata;
            else if (c_day) day_q <= c_mon ? RST_DAY : bcd_inc(day_q);
            if (tw_hi && tp == PTR_MONDAY) mon_q <= time_wdata;
            else if (c_mon) mon_q <= c_yr ? RST_MONTH : bcd_inc(mon_q);
            if (tw_lo && tp == PTR_YEAR) yr_q <= time_wdata;
            else if (c_yr) yr_q <= (yr_q == BCD_99) ? RST_ZERO : bcd_inc(yr_q);
        end
    end

    // ==========================================
    // alarm value registers
    always_ff @(posedge clock) begin
        if (srst) begin
            {asec_q, amin_q, ahr_q, awd_q} <= {4{RST_ZERO}};
            aday_q <= RST_DAY;
            amon_q <= RST_MONTH;
        end else begin
            if (alarm_lo_wr && ap == PTR_MINSEC) asec_q <= alarm_wdata;
            if (alarm_hi_wr && ap == PTR_MINSEC) amin_q <= alarm_wdata;
            if (alarm_lo_wr && ap == PTR_WDHR)   ahr_q  <= alarm_wdata;
            if (alarm_hi_wr && ap == PTR_WDHR)   awd_q  <= alarm_wdata;
            if (alarm_lo_wr && ap == PTR_MONDAY) aday_q <= alarm_wdata;
            if (alarm_hi_wr && ap == PTR_MONDAY) amon_q <= alarm_wdata;
        end
    end

    // ==========================================
    // masked digit compare
    wire [3:0] iv    = alarm_interval_select_q;
    wire m_s1  = sec_q[3:0] == asec_q[3:0];
    wire m_s   = m_s1 && sec_q[7:4] == asec_q[7:4];
    wire m_m1  = m_s && min_q[3:0] == amin_q[3:0];
    wire m_m   = m_m1 && min_q[7:4] == amin_q[7:4];
    wire m_h   = m_m && hr_q == ahr_q;
    wire m_dm  = m_h && day_q == aday_q;
    wire match = (iv == IV_HALF)  ? 1'b1
               : (iv == IV_SEC)   ? ~half_sec_phase
               : (iv == IV_10SEC) ? m_s1
               : (iv == IV_MIN)   ? m_s
               : (iv == IV_10MIN) ? m_m1
               : (iv == IV_HOUR)  ? m_m
               : (iv == IV_DAY)   ? m_h
               : (iv == IV_WEEK)  ? (m_h && wd_q == awd_q)
               : (iv == IV_MONTH) ? m_dm
               : (iv == IV_YEAR)  ? (m_dm && mon_q == amon_q)
               : 1'b0;
    wire event_now = chk_q & alarm_enable_bit_q & match;
    wire last_one  = alarm_repeat_count_q == 8'h00;

    // ==========================================
    // alarm control
    always_ff @(posedge clock) begin
        if (srst) begin
            chk_q                   <= 1'b0;
            alarm_enable_bit_q      <= 1'b0;
            endless_repeat_q        <= 1'b0;
            alarm_interval_select_q <= IV_HALF;
            alarm_repeat_count_q    <= RST_ZERO;
            drift_trim_value_q      <= RST_ZERO;
            output_pin_select_q     <= PIN_ALARM;
        end else begin
            chk_q <= half_tick;
            if (alarm_cfg_wr) begin
                alarm_enable_bit_q      <= cfg_enable;
                endless_repeat_q        <= cfg_endless;
                alarm_interval_select_q <= cfg_interval;
            end else if (event_now && last_one && !endless_repeat_q) begin
                alarm_enable_bit_q <= 1'b0;
            end
            if (repeat_wr)
                alarm_repeat_count_q <= repeat_wdata;
            else if (event_now && (!last_one || endless_repeat_q))
                alarm_repeat_count_q <= alarm_repeat_count_q - 8'h01;
            if (trim_wr)
                drift_trim_value_q <= trim_wdata;
            if (pin_sel_wr)
                output_pin_select_q <= pin_sel_wdata;
        end
    end

    // ==========================================
    // interrupt, wake, alarm pulse and pin
    always_ff @(posedge clock) begin
        if (srst) begin
            alarm_irq_q   <= 1'b0;
            wake_req_q    <= 1'b0;
            alarm_pulse_q <= 1'b0;
            cal_out_pin_q <= 1'b0;
        end else begin
            alarm_irq_q   <= event_now;
            wake_req_q    <= event_now;
            if (event_now)
                alarm_pulse_q <= ~alarm_pulse_q;
            cal_out_pin_q <= (output_pin_select_q == PIN_ALARM) ? alarm_pulse_q
                                                                : ~half_sec_phase;
        end
    end

    // ==========================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_time_ptr_dec: assert property (tp_dec && !time_ptr_wr |=>
        time_window_pointer_q == $past(time_window_pointer_q) - 2'h1)
        else $error("time pointer did not decrement");
    a_time_ptr_hold: assert property ((time_hi_wr || time_hi_rd) && !time_ptr_wr
        && time_window_pointer_q == PTR_MINSEC |=> time_window_pointer_q == PTR_MINSEC)
        else $error("time pointer left 00");
    a_alarm_ptr_dec: assert property (ap_dec && !alarm_ptr_wr |=>
        alarm_window_pointer_q == $past(alarm_window_pointer_q) - 2'h1)
        else $error("alarm pointer did not decrement");
    a_locked_write: assert property (time_hi_wr && !timer_write_unlock_q && !sec_tick
        |=> $stable(min_q) && $stable(wd_q) && $stable(mon_q))
        else $error("locked time write took effect");
    a_unlock_gate: assert property (unlock_wr && unlock_wdata && key_q != KEY_OPEN
        |=> !timer_write_unlock_q)
        else $error("unlock set outside key window");
    a_final_disable: assert property (event_now && last_one && !endless_repeat_q
        && !alarm_cfg_wr |=> !alarm_enable_bit_q)
        else $error("alarm not disabled after last event");
    a_repeat_wrap: assert property (event_now && last_one && endless_repeat_q && !repeat_wr
        |=> alarm_repeat_count_q == RPT_WRAP && alarm_enable_bit_q)
        else $error("endless repeat did not wrap");
    a_irq_event: assert property (event_now |=> alarm_irq_q && wake_req_q
        && alarm_pulse_q != $past(alarm_pulse_q))
        else $error("alarm event missing irq or pulse");
    a_pulse_quiet: assert property (!event_now |=> $stable(alarm_pulse_q))
        else $error("alarm pulse moved without event");
    a_pin_select: assert property (output_pin_select_q == PIN_ALARM
        && $stable(output_pin_select_q) |=> cal_out_pin_q == $past(alarm_pulse_q))
        else $error("pin does not follow alarm pulse");

    c_final_alarm: cover property (event_now && last_one && !endless_repeat_q);
    c_endless_wrap: cover property (event_now && last_one && endless_repeat_q);
    c_unlock: cover property (unlock_set);
    c_locked_try: cover property (time_hi_wr && !timer_write_unlock_q);
endmodule : calendar_window_alarm_trim

/* File: tb_top.sv */
// Purpose: self-checking bench for calendar_window_alarm_trim
// Assumes: half second shortened to 8 calendar pulses
// Notes:   strobes are set just after an edge and cleared by go
`timescale 1ns/10ps
module tb_top;
    import cal_pkg::*;
    // ==========================================
    // signals
    logic clock = 0, srst = 1, cal_clk_pin = 0, timer_enable = 1, unlock_wdata = 0;
    logic key_wr = 0, unlock_wr = 0, time_ptr_wr = 0, time_hi_wr = 0, time_lo_wr = 0;
    logic time_hi_rd = 0, time_lo_rd = 0, alarm_ptr_wr = 0, alarm_hi_wr = 0, alarm_lo_wr = 0;
    logic alarm_hi_rd = 0, alarm_lo_rd = 0, alarm_cfg_wr = 0, repeat_wr = 0, trim_wr = 0;
    logic pin_sel_wr = 0, cfg_enable = 0, cfg_endless = 0, prev;
    logic [1:0] time_ptr_wdata = 0, alarm_ptr_wdata = 0, pin_sel_wdata = 0;
    logic [3:0] cfg_interval = 0;
    logic [7:0] key_wdata = 0, time_wdata = 0, alarm_wdata = 0, repeat_wdata = 0, trim_wdata = 0;
    logic timer_write_unlock_q, endless_repeat_q, alarm_enable_bit_q, rollover_pending_flag;
    logic half_sec_phase, alarm_irq_q, wake_req_q, alarm_pulse_q, cal_out_pin_q;
    logic [1:0] time_window_pointer_q, alarm_window_pointer_q, output_pin_select_q;
    logic [3:0] alarm_interval_select_q;
    logic [7:0] time_window_high_q, time_window_low_q, alarm_window_high_q, alarm_window_low_q;
    logic [7:0] alarm_repeat_count_q, drift_trim_value_q;
    int bad_count = 0, checks = 0, irqs, wakes;
    calendar_window_alarm_trim #(.HALF_PULSES(8)) dut (.*);
    always #4 clock = ~clock;
    always #23 cal_clk_pin = ~cal_clk_pin;
    // ==========================================
    // tasks
    task go;
        @(posedge clock);
        {key_wr, unlock_wr, time_ptr_wr, time_hi_wr, time_lo_wr, time_hi_rd, time_lo_rd} <= '0;
        {alarm_ptr_wr, alarm_hi_wr, alarm_lo_wr, alarm_hi_rd, alarm_lo_rd} <= '0;
        {alarm_cfg_wr, repeat_wr, trim_wr, pin_sel_wr} <= '0;
        #1;
    endtask : go
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            $display("Error %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask : chk
    task count_alarms(input int cyc);
        irqs = 0;
        wakes = 0;
        repeat (cyc) begin
            go;
            irqs += int'(alarm_irq_q === 1'b1);
            wakes += int'(wake_req_q === 1'b1);
        end
    endtask : count_alarms
    task wait_low;
        int n;
        n = 0;
        while (rollover_pending_flag !== 1'b0 && n < 100) begin go; n++; end
        if (rollover_pending_flag !== 1'b0) begin
            $display("Error %0t: rollover flag stuck high", $time);
            bad_count++;
        end
    endtask : wait_low
    task trim_run(input logic [7:0] t, input int n, input logic [7:0] e);
        timer_enable <= 0; trim_wr <= 1; trim_wdata <= t; go;
        chk(drift_trim_value_q, t);
        time_lo_wr <= 1; time_wdata <= BCD_59; timer_enable <= 1; go;
        repeat (n) go;
        time_lo_rd <= 1; go; chk(time_window_low_q, e);
    endtask : trim_run
    task wrap_up;
        if (bad_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    // ==========================================
    // sequence
    initial begin
        repeat (20) go;
        srst <= 1'b0;
        go;
        time_lo_wr <= 1; time_hi_wr <= 1; time_wdata <= 8'h42; go;
        time_lo_rd <= 1; go; chk(time_window_low_q, 8'h00);
        unlock_wr <= 1; unlock_wdata <= 1; go; chk(8'(timer_write_unlock_q), 8'h00);
        key_wr <= 1; key_wdata <= KEY_FIRST; go;
        key_wr <= 1; key_wdata <= KEY_SECOND; go;
        unlock_wr <= 1; unlock_wdata <= 1; go; chk(8'(timer_write_unlock_q), 8'h01);
        time_ptr_wr <= 1; time_ptr_wdata <= PTR_YEAR; go;
        time_lo_wr <= 1; time_wdata <= 8'h24; go;
        time_hi_wr <= 1; go; chk(8'(time_window_pointer_q), 8'h02);
        time_lo_wr <= 1; time_wdata <= 8'h15; go;
        time_hi_wr <= 1; time_wdata <= 8'h07; go;
        time_ptr_wr <= 1; go;
        time_lo_rd <= 1; go; chk(time_window_low_q, 8'h24);
        time_hi_rd <= 1; go; chk(time_window_high_q, 8'h00);
        time_lo_rd <= 1; go; chk(time_window_low_q, 8'h15);
        time_hi_rd <= 1; go; chk(time_window_high_q, 8'h07);
        repeat (2) begin time_hi_rd <= 1; go; end
        chk(8'(time_window_pointer_q), 8'h00);
        alarm_ptr_wr <= 1; alarm_ptr_wdata <= PTR_MONDAY; go;
        alarm_lo_wr <= 1; alarm_wdata <= 8'h09; go;
        alarm_hi_wr <= 1; alarm_wdata <= 8'h11; go; chk(8'(alarm_window_pointer_q), 8'h01);
        alarm_ptr_wr <= 1; go;
        alarm_lo_rd <= 1; go; chk(alarm_window_low_q, 8'h09);
        alarm_hi_rd <= 1; go; chk(alarm_window_high_q, 8'h11);
        repeat (2) begin alarm_hi_rd <= 1; go; end
        chk(8'(alarm_window_pointer_q), 8'h00);
        wait_low;
        repeat_wr <= 1; repeat_wdata <= 8'h01; go;
        alarm_cfg_wr <= 1; cfg_enable <= 1; cfg_interval <= IV_HALF; go;
        count_alarms(600);
        chk(8'(irqs), 8'h02);
        chk(8'(wakes), 8'h02);
        chk(8'(alarm_enable_bit_q), 8'h00);
        chk(8'(alarm_pulse_q), 8'h00);
        chk(8'(cal_out_pin_q), 8'h00);
        wait_low;
        alarm_cfg_wr <= 1; cfg_endless <= 1; go;
        chk(8'(endless_repeat_q), 8'h01);
        chk(8'(alarm_interval_select_q), 8'(IV_HALF));
        count_alarms(200);
        chk(8'(irqs >= 3), 8'h01);
        chk(alarm_repeat_count_q, 8'(256 - irqs));
        chk(8'(alarm_enable_bit_q), 8'h01);
        pin_sel_wr <= 1; pin_sel_wdata <= 2'h1; go;
        chk(8'(output_pin_select_q), 8'h01);
        repeat (60) begin prev = ~half_sec_phase; go; chk(8'(cal_out_pin_q), 8'(prev)); end
        wait_low;
        alarm_cfg_wr <= 1; cfg_enable <= 0; go;
        // trim +1 ends second 00 four pulses early, trim -1 four pulses late
        trim_run(8'h01, 173, 8'h01);
        trim_run(8'hff, 196, 8'h00);
        wrap_up;
    end
endmodule : tb_top
